// [ssi_slave.sv]
// Purpose: Sensor end of the two-wire link with data-ready pin
// Assumes: link_clk far faster than the bus bit rate
// Notes: clk side takes measurements, link_clk side serves the bus
// Functional notes
// RULE1 - Data falling while clock high opens transaction
// RULE2 - Data rising while clock high ends transaction
// RULE3 - Only the master creates start and stop
// RULE4 - Bus busy from start until free time passes
// RULE5 - Idle bus leaves both lines released high
// RULE6 - Lines are only pulled low or released
// RULE7 - Bytes are eight bits, MSB first
// RULE8 - Any number of bytes per transfer
// RULE9 - Ninth clock carries acknowledge, master clocks all
// RULE10 - Transmitter releases data, receiver pulls low
// RULE11 - High ninth bit is not-acknowledge, then stop; with cmd_chain set the master sends a repeated start instead
// RULE12 - Slave may stretch clock low between bytes
// RULE13 - First byte is address plus direction bit
// RULE14 - Master chains transfers with repeated start
// RULE15 - Master rate at most 100 or 400 kbit/s
// RULE16 - Ready pin rises on data, falls on access
// RULE17 - Ready pin drives both levels
// RULE18 - Read returns bridge, bridge, temperature, temperature bytes
// RULE19 - Status 00 fresh, 10 stale, 11 fault
// RULE20 - Master avoids start then stop without clocks
// RULE21 - Master keeps data steady until first clock
// RULE22 - Own address is a parameter; match required
`timescale 1ns/1ps
module ssi_slave
   import ssi_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEF,
   parameter int LOAD_P = LOAD_CYC
) (
   input wire logic clk,                      // Measurement clock
   input wire logic rst,                      // Synchronous reset
   input wire logic link_clk,                 // Link-side clock
   ssi_if.slave bus,                          // Two-wire bus
   input wire logic meas_valid,               // New measurement pulse
   input wire logic [BRIDGE_W-1:0] meas_bridge, // Bridge value
   input wire logic [TEMP_W-1:0] meas_temp,   // Temperature value
   input wire logic meas_fault,               // Fault with this sample
   output logic drdy                          // Data-ready pin
);
   // clk domain
   logic req_q, ack_s, com_s, com_p_q, flt_q;
   logic [BRIDGE_W-1:0] br_q;
   logic [TEMP_W-1:0] tp_q;
   // link domain
   logic lrst, req_s, seen_q, new_ev, com_t_q;
   logic [1:0] pin_s;
   logic scl_p_q, sda_p_q, rise, fall, start, stop;
   logic [BRIDGE_W-1:0] snap_br_q, rd_br_q;
   logic [TEMP_W-1:0] snap_tp_q, rd_tp_q;
   logic fresh_q, fault_q, mack_q, rw_q, scl_oe_q, sda_oe_q;
   ssi_slv_t st_q;
   logic [3:0] bit_q, cnt_q;
   logic [2:0] idx_q;
   logic [7:0] sh_q, pkt, first;
   logic [1:0] stat;
   logic load_end;

   // Measurement capture; a new one is dropped until the link takes the last
   always_ff @(posedge clk) begin
      if (rst) begin
         req_q <= 1'b0;
         br_q <= '0;
         tp_q <= '0;
         flt_q <= 1'b0;
      end else if (meas_valid && (req_q == ack_s)) begin
         br_q <= meas_bridge;
         tp_q <= meas_temp;
         flt_q <= meas_fault;
         req_q <= ~req_q;
      end
   end

   ssi_sync u_ack (.clk(clk), .rst(rst), .d(seen_q), .q(ack_s));
   ssi_sync u_com (.clk(clk), .rst(rst), .d(com_t_q), .q(com_s));

   always_ff @(posedge clk) begin
      if (rst) com_p_q <= 1'b0;
      else com_p_q <= com_s;
   end

   // Push-pull ready pin; a new sample wins over an access
   always_ff @(posedge clk) begin
      if (rst) drdy <= 1'b0; // [RULE17]
      else if (meas_valid) drdy <= 1'b1; // [RULE16]
      else if (com_s ^ com_p_q) drdy <= 1'b0; // [RULE16]
   end

   ssi_sync u_lrst (.clk(link_clk), .rst(1'b0), .d(rst), .q(lrst));
   ssi_sync u_req (.clk(link_clk), .rst(lrst), .d(req_q), .q(req_s));
   ssi_sync #(.W(2), .RST_VAL(2'h3)) u_pin (
      .clk(link_clk), .rst(lrst), .d({bus.scl, bus.sda}), .q(pin_s));

   assign new_ev = req_s ^ seen_q;
   assign rise = pin_s[1] && !scl_p_q;
   assign fall = !pin_s[1] && scl_p_q;
   assign start = pin_s[1] && scl_p_q && sda_p_q && !pin_s[0]; // [RULE1]
   assign stop = pin_s[1] && scl_p_q && !sda_p_q && pin_s[0];  // [RULE2]
   assign load_end = (st_q == S_LOAD) && (cnt_q == 4'h0);
   assign bus.scl_s_oe = scl_oe_q; // [RULE5] [RULE6]
   assign bus.sda_s_oe = sda_oe_q; // [RULE6]

   always_ff @(posedge link_clk) begin
      if (lrst) begin
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_p_q <= pin_s[1];
         sda_p_q <= pin_s[0];
      end
   end

   // Snapshot of the latest sample and the sticky fault state
   always_ff @(posedge link_clk) begin
      if (lrst) begin
         seen_q <= 1'b0;
         snap_br_q <= '0;
         snap_tp_q <= '0;
         fault_q <= 1'b0;
      end else if (new_ev) begin
         seen_q <= req_s;
         snap_br_q <= br_q;
         snap_tp_q <= tp_q;
         fault_q <= fault_q | flt_q; // Sticky until reset
      end
   end

   // Fresh until fetched; a new sample wins over the fetch
   always_ff @(posedge link_clk) begin
      if (lrst) fresh_q <= 1'b0;
      else if (new_ev) fresh_q <= 1'b1;
      else if (load_end) fresh_q <= 1'b0; // [RULE19]
   end

   always_comb begin
      stat = fault_q ? ST_FAULT : (fresh_q ? ST_FRESH : ST_STALE); // [RULE19]
      first = {stat, snap_br_q[13:8]}; // [RULE18]
      unique case (idx_q)
         3'h1: pkt = rd_br_q[7:0];
         3'h2: pkt = rd_tp_q[10:3];
         3'h3: pkt = {rd_tp_q[2:0], TEMP_PAD};
         default: pkt = FILL_BYTE; // [RULE8]
      endcase
   end

   // Access event toward the ready pin
   always_ff @(posedge link_clk) begin
      if (lrst) com_t_q <= 1'b0;
      else if (st_q == S_ADDR && fall && bit_q == ACK_BIT
               && sh_q[7:1] == DEV_ADDR) com_t_q <= ~com_t_q; // [RULE16]
   end

   always_ff @(posedge link_clk) begin
      if (lrst) begin
         st_q <= S_IDLE;
         bit_q <= 4'h0;
         cnt_q <= 4'h0;
         idx_q <= 3'h0;
         sh_q <= 8'h00;
         rw_q <= 1'b0;
         mack_q <= 1'b0;
         scl_oe_q <= 1'b0;
         sda_oe_q <= 1'b0;
         rd_br_q <= '0;
         rd_tp_q <= '0;
      end else if (start) begin // [RULE1] [RULE14]
         st_q <= S_ADDR;
         bit_q <= 4'h0;
         scl_oe_q <= 1'b0;
         sda_oe_q <= 1'b0;
      end else if (stop) begin // [RULE2] [RULE5]
         st_q <= S_IDLE;
         scl_oe_q <= 1'b0;
         sda_oe_q <= 1'b0;
      end else begin
         unique case (st_q)
            S_IDLE: ;
            S_ADDR: begin // [RULE13]
               if (rise) begin
                  sh_q <= {sh_q[6:0], pin_s[0]}; // [RULE7]
                  bit_q <= bit_q + 4'h1;
               end else if (fall && bit_q == ACK_BIT) begin
                  if (sh_q[7:1] == DEV_ADDR) begin // [RULE22]
                     rw_q <= sh_q[0];
                     sda_oe_q <= 1'b1; // [RULE10]
                     st_q <= S_AACK;
                  end else st_q <= S_IDLE;
               end
            end
            S_AACK: if (fall) begin // [RULE9]
               sda_oe_q <= 1'b0;
               bit_q <= 4'h0;
               if (rw_q == RW_READ) begin
                  scl_oe_q <= 1'b1; // [RULE12]
                  cnt_q <= 4'(LOAD_P);
                  st_q <= S_LOAD;
               end else st_q <= S_RX;
            end
            S_LOAD: begin
               if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
               else begin
                  rd_br_q <= snap_br_q;
                  rd_tp_q <= snap_tp_q;
                  sh_q <= first; // [RULE18]
                  sda_oe_q <= ~first[7];
                  bit_q <= 4'h1;
                  idx_q <= 3'h1;
                  scl_oe_q <= 1'b0; // [RULE12]
                  st_q <= S_TX;
               end
            end
            S_TX: if (fall) begin // [RULE7]
               if (bit_q == ACK_BIT) begin
                  sda_oe_q <= 1'b0; // [RULE10]
                  st_q <= S_TACK;
               end else begin
                  sda_oe_q <= ~sh_q[6];
                  sh_q <= {sh_q[6:0], 1'b0};
                  bit_q <= bit_q + 4'h1;
               end
            end
            S_TACK: begin
               if (rise) mack_q <= ~pin_s[0];
               else if (fall) begin
                  if (mack_q) begin // [RULE8]
                     sh_q <= pkt;
                     sda_oe_q <= ~pkt[7];
                     bit_q <= 4'h1;
                     if (idx_q != 3'h4) idx_q <= idx_q + 3'h1;
                     st_q <= S_TX;
                  end else st_q <= S_IDLE; // [RULE11]
               end
            end
            S_RX: begin
               if (rise) bit_q <= bit_q + 4'h1;
               else if (fall && bit_q == ACK_BIT) begin
                  sda_oe_q <= 1'b1; // [RULE10]
                  st_q <= S_RACK;
               end
            end
            S_RACK: if (fall) begin // [RULE8]
               sda_oe_q <= 1'b0;
               bit_q <= 4'h0;
               st_q <= S_RX;
            end
         endcase
      end
   end
endmodule : ssi_slave

// [ssi_pkg.sv]
// Purpose: Shared constants and state types of the sensor two-wire link
// Assumes: 250 MHz master clock, link clock seen by the device end
// Notes: Bit and bus free counts derive from figures in nanoseconds; the stretch count is in link clocks
package ssi_pkg;
   localparam int CLK_NS = 4;            // Master clock period
   localparam int STD_PERIOD_NS = 10000; // 100 kbit/s bit time
   localparam int FAST_PERIOD_NS = 2500; // 400 kbit/s bit time
   // Least quarter-bit, rounded up so the rate is never exceeded
   localparam int QTR_STD = (STD_PERIOD_NS + 4 * CLK_NS - 1) / (4 * CLK_NS);
   localparam int QTR_FAST = (FAST_PERIOD_NS + 4 * CLK_NS - 1) / (4 * CLK_NS);
   localparam int BUS_FREE_NS = 2000;    // Bus free time after a stop
   localparam int BUS_FREE_CYC = (BUS_FREE_NS + CLK_NS - 1) / CLK_NS;
   localparam int LOAD_CYC = 4;          // Device stretch, link clocks
   localparam logic [6:0] DEV_ADDR_DEF = 7'h28;
   localparam int BYTE_W = 8;
   localparam int BRIDGE_W = 14;
   localparam int TEMP_W = 11;
   localparam logic [3:0] ACK_BIT = 4'h8; // Ninth bit index
   localparam logic RW_READ = 1'b1;
   localparam logic [1:0] ST_FRESH = 2'h0;
   localparam logic [1:0] ST_STALE = 2'h2;
   localparam logic [1:0] ST_FAULT = 2'h3;
   localparam logic [4:0] TEMP_PAD = 5'h00;
   localparam logic [7:0] FILL_BYTE = 8'h00;

   typedef enum logic [4:0] {
      M_IDLE = 5'b00001,
      M_START = 5'b00010,
      M_BIT = 5'b00100,
      M_STOP = 5'b01000,
      M_FREE = 5'b10000
   } ssi_mst_t;

   typedef enum logic [7:0] {
      S_IDLE = 8'b00000001,
      S_ADDR = 8'b00000010,
      S_AACK = 8'b00000100,
      S_LOAD = 8'b00001000,
      S_TX = 8'b00010000,
      S_TACK = 8'b00100000,
      S_RX = 8'b01000000,
      S_RACK = 8'b10000000
   } ssi_slv_t;
endpackage : ssi_pkg

// [ssi_if.sv]
// Purpose: Two-wire bus between master end and sensor end
// Assumes: Pull-up on both lines, every party only pulls low
// Notes: Line level is the NOR of all pull-down enables
`timescale 1ns/1ps
interface ssi_if;
   logic scl_m_oe; // Master pulls clock low
   logic sda_m_oe; // Master pulls data low
   logic scl_s_oe; // Sensor pulls clock low
   logic sda_s_oe; // Sensor pulls data low
   logic scl;      // Resolved clock line
   logic sda;      // Resolved data line

   assign scl = ~(scl_m_oe | scl_s_oe);
   assign sda = ~(sda_m_oe | sda_s_oe);

   modport master(output scl_m_oe, output sda_m_oe, input scl, input sda);
   modport slave(output scl_s_oe, output sda_s_oe, input scl, input sda);
endinterface : ssi_if

// [ssi_sync.sv]
// Purpose: Two-flop synchroniser for levels entering a clock domain
// Assumes: Each bit is an independent level
// Notes: First stage feeds only the second
`timescale 1ns/1ps
module ssi_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk,        // Destination clock
   input wire logic rst,        // Synchronous reset, high
   input wire logic [W-1:0] d,  // Asynchronous level
   output logic [W-1:0] q       // Synchronised level
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         meta_q <= RST_VAL;
         q <= RST_VAL;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule : ssi_sync

// [ssi_master.sv]
// Purpose: Bus master end, makes the bus clock from clk by division
// Assumes: Read commands ask for at least one byte
// Notes: Clock stretching by the sensor freezes the bit timer
`timescale 1ns/1ps
module ssi_master
   import ssi_pkg::*;
#(
   parameter int QTR_STD_P = QTR_STD,
   parameter int QTR_FAST_P = QTR_FAST,
   parameter int FREE_P = BUS_FREE_CYC,
   parameter int LEN_W = 8
) (
   input wire logic clk,               // System clock
   input wire logic rst,               // Synchronous reset
   ssi_if.master bus,                  // Two-wire bus
   input wire logic fast_mode,         // 1: 400 kbit/s, 0: 100 kbit/s
   input wire logic cmd_valid,         // Command present
   input wire logic cmd_read,          // 1 read, 0 write
   input wire logic [6:0] cmd_addr,    // Target address
   input wire logic [LEN_W-1:0] cmd_len, // Data byte count
   input wire logic cmd_chain,         // Follow with repeated start
   input wire logic [7:0] wr_data,     // Next byte to write
   output logic cmd_take,              // Command taken pulse
   output logic wr_take,               // Write byte taken pulse
   output logic [7:0] rd_data,         // Byte read
   output logic rd_valid,              // Read byte pulse
   output logic done,                  // Stop sent pulse
   output logic nack,                  // Target refused a byte
   output logic bus_busy               // Command taken, free time not over
);
   ssi_mst_t st_q;
   logic [1:0] pin_s, ph_q;
   logic [3:0] bit_q;
   logic [7:0] sh_q;
   logic [6:0] adr_q;
   logic [LEN_W-1:0] len_q;
   logic [11:0] q_q, rel;
   logic [15:0] free_q;
   logic rd_q, chain_q, is_adr_q, scl_oe_q, sda_oe_q, stall, tick;
   logic tx_now, drv, fin, accept;

   ssi_sync #(.W(2), .RST_VAL(2'h3)) u_pin (
      .clk(clk), .rst(rst), .d({bus.scl, bus.sda}), .q(pin_s));

   assign bus.scl_m_oe = scl_oe_q; // [RULE5] [RULE6]
   assign bus.sda_m_oe = sda_oe_q; // [RULE6]
   always_ff @(posedge clk) bus_busy <= !rst && st_q != M_IDLE; // [RULE4]

   assign rel = fast_mode ? 12'(QTR_FAST_P - 1) : 12'(QTR_STD_P - 1);
   assign stall = (ph_q == 2'h3) && !pin_s[1]; // [RULE12]
   assign tick = (q_q == 12'h000) && !stall;
   assign tx_now = is_adr_q || !rd_q;
   // Data bits MSB first; ack low on reads unless the last byte
   assign drv = (bit_q != ACK_BIT) ? (tx_now & ~sh_q[7]) // [RULE7]
              : (!tx_now && (len_q != LEN_W'(1)));        // [RULE10] [RULE11]
   assign fin = (st_q == M_BIT) && tick && (ph_q == 2'h3)
              && (bit_q == ACK_BIT)
              && (tx_now ? (pin_s[0] || (!(is_adr_q && rd_q)
                 && len_q == '0)) : (len_q == LEN_W'(1)));
   assign accept = cmd_valid && ((st_q == M_IDLE) || (fin && chain_q));

   // Quarter-bit timer (bus clock derived by division)
   always_ff @(posedge clk) begin // [RULE15]
      if (rst || st_q == M_IDLE) q_q <= rel;
      else if (!stall) q_q <= (q_q == 12'h000) ? rel : q_q - 12'h001;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_q <= M_IDLE;
         ph_q <= 2'h0;
         bit_q <= 4'h0;
         sh_q <= 8'h00;
         adr_q <= 7'h00;
         len_q <= '0;
         rd_q <= 1'b0;
         chain_q <= 1'b0;
         is_adr_q <= 1'b0;
         scl_oe_q <= 1'b0;
         sda_oe_q <= 1'b0;
         free_q <= 16'h0000;
         cmd_take <= 1'b0;
         wr_take <= 1'b0;
         rd_data <= 8'h00;
         rd_valid <= 1'b0;
         done <= 1'b0;
         nack <= 1'b0;
      end else begin
         cmd_take <= 1'b0;
         wr_take <= 1'b0;
         rd_valid <= 1'b0;
         done <= 1'b0;
         unique case (st_q)
            M_IDLE: begin
               if (cmd_valid) nack <= 1'b0;
            end
            M_START: if (tick) begin // [RULE1] [RULE3] [RULE14]
               ph_q <= ph_q + 2'h1;
               unique case (ph_q)
                  2'h0: scl_oe_q <= pin_s[1] && !pin_s[0];
                  2'h1: sda_oe_q <= 1'b0;
                  2'h2: scl_oe_q <= 1'b0;
                  2'h3: begin
                     sda_oe_q <= 1'b1;
                     sh_q <= {adr_q, rd_q}; // [RULE13] [RULE20] [RULE21]
                     is_adr_q <= 1'b1;
                     bit_q <= 4'h0;
                     st_q <= M_BIT;
                  end
               endcase
            end
            M_BIT: if (tick) begin // [RULE9]
               ph_q <= ph_q + 2'h1;
               unique case (ph_q)
                  2'h0: scl_oe_q <= 1'b1;
                  2'h1: sda_oe_q <= drv;
                  2'h2: scl_oe_q <= 1'b0;
                  2'h3: begin
                     if (bit_q != ACK_BIT) begin
                        sh_q <= {sh_q[6:0], pin_s[0]};
                        bit_q <= bit_q + 4'h1;
                     end else begin
                        bit_q <= 4'h0;
                        if (tx_now) begin
                           if (pin_s[0]) nack <= 1'b1; // [RULE11]
                           else if (is_adr_q && rd_q) is_adr_q <= 1'b0;
                           else if (len_q != '0) begin // [RULE8]
                              sh_q <= wr_data;
                              wr_take <= 1'b1;
                              len_q <= len_q - LEN_W'(1);
                              is_adr_q <= 1'b0;
                           end
                        end else begin
                           rd_data <= sh_q;
                           rd_valid <= 1'b1;
                           len_q <= len_q - LEN_W'(1);
                        end
                        if (fin) st_q <= M_STOP;
                     end
                  end
               endcase
            end
            M_STOP: if (tick) begin // [RULE2] [RULE3]
               ph_q <= ph_q + 2'h1;
               unique case (ph_q)
                  2'h0: scl_oe_q <= 1'b1;
                  2'h1: sda_oe_q <= 1'b1;
                  2'h2: scl_oe_q <= 1'b0;
                  2'h3: begin
                     sda_oe_q <= 1'b0;
                     done <= 1'b1;
                     free_q <= 16'(FREE_P);
                     st_q <= M_FREE;
                  end
               endcase
            end
            M_FREE: begin // [RULE4]
               if (free_q == 16'h0000) st_q <= M_IDLE;
               else free_q <= free_q - 16'h0001;
            end
         endcase
         if (accept) begin
            adr_q <= cmd_addr;
            rd_q <= cmd_read;
            len_q <= cmd_len;
            chain_q <= cmd_chain;
            cmd_take <= 1'b1;
            ph_q <= 2'h0;
            st_q <= M_START;
         end
      end
   end
endmodule : ssi_master

// [ssi_props.sv]
// Purpose: Concurrent checks on the sensor two-wire bus
// Assumes: Master clock far faster than the bit rate
// Notes: Helper logic tracks bit position and the address byte
`timescale 1ns/1ps
module ssi_props
   import ssi_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEF,
   parameter int FREE_P = BUS_FREE_CYC
) (
   input wire logic clk,      // Master clock
   input wire logic rst,      // Synchronous reset
   input wire logic link_clk, // Sensor link clock
   input wire logic scl_m_oe, // Master clock pull
   input wire logic sda_m_oe, // Master data pull
   input wire logic scl_s_oe, // Sensor clock pull
   input wire logic sda_s_oe, // Sensor data pull
   input wire logic scl,      // Clock line
   input wire logic sda       // Data line
);
   logic scl_q, sda_q, nine_q, first_q, start, stop, rise;
   logic [3:0] bit_q;
   logic [7:0] sh_q;
   int free_q;

   assign start = scl && scl_q && sda_q && !sda;
   assign stop = scl && scl_q && !sda_q && sda;
   assign rise = scl && !scl_q;

   always_ff @(posedge clk) begin
      scl_q <= rst | scl;
      sda_q <= rst | sda;
   end

   // Bit position, ninth pulse and first byte after a start
   always_ff @(posedge clk) begin
      if (rst || start || stop) begin
         bit_q <= 4'h0;
         nine_q <= 1'b0;
         first_q <= !rst && start;
      end else if (rise) begin
         nine_q <= (bit_q == ACK_BIT);
         bit_q <= (bit_q == ACK_BIT) ? 4'h0 : bit_q + 4'h1;
         first_q <= first_q && (bit_q != ACK_BIT);
         sh_q <= {sh_q[6:0], sda};
      end else if (!scl) begin
         nine_q <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst)
         free_q <= FREE_P;
      else if (stop)
         free_q <= 0;
      else if (free_q < FREE_P)
         free_q <= free_q + 1;
   end

   sequence s_stop;
      scl && $past(scl) && $rose(sda);
   endsequence
   sequence s_quiet;
      (!scl_m_oe && !sda_m_oe && !scl_s_oe && !sda_s_oe)[*8];
   endsequence

   a_idle_lines_free:
   assert property (@(posedge clk) disable iff (rst) s_stop |-> s_quiet)
      else $error("lines held after stop");
   a_bus_free_time:
   assert property (@(posedge clk) disable iff (rst) start |-> free_q >= FREE_P)
      else $error("start too early");
   a_sensor_data_steady:
   assert property (@(posedge link_clk) disable iff (rst)
      scl && $past(scl) |-> $stable(sda_s_oe))
      else $error("sensor data moved");
   a_stretch_when_low:
   assert property (@(posedge clk) disable iff (rst)
      $rose(scl_s_oe) |-> !$past(scl)) else $error("stretch while high");
   a_stretch_bounded:
   assert property (@(posedge clk) disable iff (rst)
      $rose(scl_s_oe) |-> ##[1:40] !scl_s_oe) else $error("stretch too long");
   a_clock_high_min:
   assert property (@(posedge clk) disable iff (rst) $rose(scl) |-> scl[*8])
      else $error("clock high too short");
   a_ack_one_driver:
   assert property (@(posedge clk) disable iff (rst)
      nine_q && scl |-> !(sda_m_oe && sda_s_oe))
      else $error("two ack drivers");
   a_ack_stable:
   assert property (@(posedge clk) disable iff (rst)
      nine_q && scl && $past(scl) |-> $stable(sda))
      else $error("ack moved");
   a_addr_ack_match:
   assert property (@(posedge clk) disable iff (rst)
      rise && bit_q == ACK_BIT && first_q |-> sda == (sh_q[7:1] != DEV_ADDR))
      else $error("address ack wrong");
endmodule : ssi_props

// [sensor_i2c_slave_interface_test.sv]
// Purpose: Self-checking bench joining master end and sensor end
// Assumes: Shortened quarter-bit and bus free counts
// Notes: Each scenario task drives commands and judges the result
`timescale 1ns/1ps
module sensor_i2c_slave_interface_test
   import ssi_pkg::*;
;
   localparam int FREE = 20;
   logic clk, rst, link_clk, fast_mode, cmd_valid, cmd_read, cmd_chain;
   logic cmd_take, wr_take, rd_valid, done, nack, bus_busy;
   logic meas_valid, meas_fault, drdy;
   logic [6:0] cmd_addr;
   logic [7:0] cmd_len, wr_data, rd_data;
   logic [BRIDGE_W-1:0] meas_bridge;
   logic [TEMP_W-1:0] meas_temp;
   logic [7:0] got[$];
   int errors, samples_checked, wcnt;

   ssi_if ssi_if_i();
   ssi_master #(.QTR_STD_P(40), .QTR_FAST_P(32), .FREE_P(FREE)) ssi_master_i(
      .clk(clk), .rst(rst), .bus(ssi_if_i.master), .fast_mode(fast_mode),
      .cmd_valid(cmd_valid), .cmd_read(cmd_read), .cmd_addr(cmd_addr),
      .cmd_len(cmd_len), .cmd_chain(cmd_chain), .wr_data(wr_data),
      .cmd_take(cmd_take), .wr_take(wr_take), .rd_data(rd_data),
      .rd_valid(rd_valid), .done(done), .nack(nack), .bus_busy(bus_busy));
   ssi_slave #(.DEV_ADDR(DEV_ADDR_DEF), .LOAD_P(LOAD_CYC)) ssi_slave_i(
      .clk(clk), .rst(rst), .link_clk(link_clk), .bus(ssi_if_i.slave),
      .meas_valid(meas_valid), .meas_bridge(meas_bridge),
      .meas_temp(meas_temp), .meas_fault(meas_fault), .drdy(drdy));
   ssi_props #(.DEV_ADDR(DEV_ADDR_DEF), .FREE_P(FREE)) ssi_props_i(
      .clk(clk), .rst(rst), .link_clk(link_clk),
      .scl_m_oe(ssi_if_i.scl_m_oe), .sda_m_oe(ssi_if_i.sda_m_oe),
      .scl_s_oe(ssi_if_i.scl_s_oe), .sda_s_oe(ssi_if_i.sda_s_oe),
      .scl(ssi_if_i.scl), .sda(ssi_if_i.sda));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      link_clk = 1'b0;
      #1.3;
      forever #7.5 link_clk = ~link_clk;
   end

   task automatic check(input string what, input logic [7:0] seen,
                        input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic test_done;
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : test_done

   task automatic sample(input logic [13:0] b, input logic [10:0] t,
                         input logic f);
      @(posedge clk);
      meas_bridge <= b;
      meas_temp <= t;
      meas_fault <= f;
      meas_valid <= 1'b1;
      @(posedge clk);
      meas_valid <= 1'b0;
      repeat (60) @(posedge clk);
   endtask : sample

   task automatic issue(input logic rd, input logic [6:0] a,
                        input logic [7:0] n, input logic ch);
      int i;
      @(posedge clk);
      cmd_read <= rd;
      cmd_addr <= a;
      cmd_len <= n;
      cmd_chain <= ch;
      cmd_valid <= 1'b1;
      #1;
      for (i = 0; i < 20000 && cmd_take !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
      check("cmd_take", cmd_take, 1'b1);
      if (cmd_take !== 1'b1)
         test_done();
      if (!ch) begin
         @(posedge clk);
         cmd_valid <= 1'b0;
      end
   endtask : issue

   task automatic collect;
      int i;
      got.delete();
      wcnt = 0;
      for (i = 0; i < 60000 && done !== 1'b1; i++) begin
         @(posedge clk);
         #1;
         if (rd_valid === 1'b1)
            got.push_back(rd_data);
         if (wr_take === 1'b1)
            wcnt++;
      end
      check("done", done, 1'b1);
      for (i = 0; i < 2000 && bus_busy !== 1'b0; i++)
         @(posedge clk);
      check("bus free", bus_busy, 1'b0);
      if (errors != 0)
         test_done();
   endtask : collect

   task automatic judge(input logic [1:0] st, input int n);
      logic [7:0] e[6];
      e = '{{st, meas_bridge[13:8]}, meas_bridge[7:0], meas_temp[10:3],
            {meas_temp[2:0], TEMP_PAD}, FILL_BYTE, FILL_BYTE};
      check("byte count", 8'(got.size()), 8'(n));
      for (int i = 0; i < n && i < got.size(); i++)
         check("read byte", got[i], e[i]);
      check("nack", nack, 1'b0);
   endtask : judge

   task automatic t_fresh_read;
      check("scl idle", ssi_if_i.scl, 1'b1);
      check("drdy reset", drdy, 1'b0);
      sample(14'h1234, 11'h5a7, 1'b0);
      check("drdy set", drdy, 1'b1);
      issue(RW_READ, DEV_ADDR_DEF, 8'h04, 1'b0);
      collect();
      judge(ST_FRESH, 4);
      check("drdy cleared", drdy, 1'b0);
      issue(RW_READ, DEV_ADDR_DEF, 8'h06, 1'b0);
      collect();
      judge(ST_STALE, 6);
   endtask : t_fresh_read

   task automatic t_writes;
      sample(14'h0abc, 11'h13d, 1'b0);
      issue(1'b0, DEV_ADDR_DEF ^ 7'h01, 8'h02, 1'b0);
      collect();
      check("nack other addr", nack, 1'b1);
      check("bytes after nack", 8'(wcnt), 8'h00);
      check("drdy kept", drdy, 1'b1);
      wr_data <= 8'h96;
      issue(1'b0, DEV_ADDR_DEF, 8'h03, 1'b0);
      collect();
      check("nack own addr", nack, 1'b0);
      check("bytes written", 8'(wcnt), 8'h03);
      check("drdy write", drdy, 1'b0);
   endtask : t_writes

   task automatic t_chain_fault;
      fast_mode <= 1'b1;
      sample(14'h2c5b, 11'h3f1, 1'b0);
      issue(1'b0, DEV_ADDR_DEF, 8'h01, 1'b1);
      issue(RW_READ, DEV_ADDR_DEF, 8'h03, 1'b0);
      collect();
      judge(ST_FRESH, 3);
      sample(14'h3001, 11'h7ff, 1'b1);
      issue(RW_READ, DEV_ADDR_DEF, 8'h02, 1'b0);
      collect();
      judge(ST_FAULT, 2);
      sample(14'h0155, 11'h002, 1'b0);
      issue(RW_READ, DEV_ADDR_DEF, 8'h04, 1'b0);
      collect();
      judge(ST_FAULT, 4);
   endtask : t_chain_fault

   initial begin
      errors = 0;
      samples_checked = 0;
      rst = 1'b1;
      fast_mode = 1'b0;
      cmd_valid = 1'b0;
      cmd_read = 1'b0;
      cmd_chain = 1'b0;
      cmd_addr = 7'h00;
      cmd_len = 8'h00;
      wr_data = 8'h5a;
      meas_valid = 1'b0;
      meas_fault = 1'b0;
      meas_bridge = '0;
      meas_temp = '0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      repeat (8) @(posedge clk);
      t_fresh_read();
      t_writes();
      t_chain_fault();
      test_done();
   end
endmodule : sensor_i2c_slave_interface_test
